// *** include/rsq_pkg.sv ***
/*
  constants for the rail sequencing register block: register offsets,
  field positions, reset values, timebase figures and channel states.
  assumes a 25 MHz system clock.
*/
package rsq_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] LINREG1_CONTROL_OFS = 8'h09;
  localparam logic [7:0] LINREG0_LEVEL_OFS = 8'h0A;
  localparam logic [7:0] LINREG1_LEVEL_OFS = 8'h0B;
  localparam logic [7:0] CONV0_SEQ_OFS = 8'h0C;
  localparam logic [7:0] CONV1_SEQ_OFS = 8'h0D;
  localparam logic [7:0] LINREG0_SEQ_OFS = 8'h0E;
  localparam logic [7:0] LINREG1_SEQ_OFS = 8'h0F;
  localparam logic [7:0] AUX_OUT_SEQ_OFS = 8'h10;
  localparam logic [7:0] CONFIG_OFS = 8'h13;

  // ==========================================================
  // field positions
  localparam int ON_BIT_POS = 0;
  localparam int PIN_GATE_POS = 1;
  localparam int BLEED_BIT_POS = 2;
  localparam int LEVEL_MSB = 4;
  localparam int ON_WAIT_MSB = 3;
  localparam int OFF_WAIT_LSB = 4;
  localparam int OFF_WAIT_MSB = 7;
  localparam int START_SCALE_POS = 6;
  localparam int STOP_SCALE_POS = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0] LINREG1_CONTROL_RST = 8'h04;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] SEQ_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // ==========================================================
  // timebase
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_TIME_NS = 500000;
  localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = 14;
  localparam int WAIT_W = 4;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;

  // ==========================================================
  // sequencing channel states
  typedef enum logic [3:0] {
    RSQ_OFF = 4'b0001,
    RSQ_WAIT_ON = 4'b0010,
    RSQ_ON = 4'b0100,
    RSQ_WAIT_OFF = 4'b1000
  } rsq_state_t;

endpackage

// *** src/rsq_channel.sv ***
/*
  one sequencing channel: raises its run output a programmed number of
  steps after the enable pin rises and drops it a programmed number of
  steps after it falls.
  assumes edge pulses and step ticks are one-cycle pulses on clk_sys.
*/
`timescale 1ns/10ps
module rsq_channel (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic en_rise,
  input wire logic en_fall,
  input wire logic tick_on,
  input wire logic tick_off,
  input wire logic [rsq_pkg::WAIT_W-1:0] on_wait,
  input wire logic [rsq_pkg::WAIT_W-1:0] off_wait,
  output logic run
);

  rsq_pkg::rsq_state_t state;
  rsq_pkg::rsq_state_t next_state;
  logic [rsq_pkg::WAIT_W-1:0] steps;
  logic [rsq_pkg::WAIT_W-1:0] next_steps;
  logic [rsq_pkg::WAIT_W-1:0] steps_inc;
  logic next_run;

  assign steps_inc = steps + rsq_pkg::WAIT_ONE;
  // waits hold the present level, so an aborted start never pulses the output on
  // and an aborted stop never drops it
  assign next_run = (next_state == rsq_pkg::RSQ_ON) || ((next_state != rsq_pkg::RSQ_OFF) && run);

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    next_steps = steps;
    if (en_rise) begin
      next_steps = rsq_pkg::WAIT_ZERO;
      next_state = (on_wait == rsq_pkg::WAIT_ZERO) ? rsq_pkg::RSQ_ON : rsq_pkg::RSQ_WAIT_ON;
    end else if (en_fall) begin
      next_steps = rsq_pkg::WAIT_ZERO;
      next_state = (off_wait == rsq_pkg::WAIT_ZERO) ? rsq_pkg::RSQ_OFF : rsq_pkg::RSQ_WAIT_OFF;
    end else begin
      unique case (state)
        rsq_pkg::RSQ_WAIT_ON: begin
          if (tick_on) begin
            next_steps = steps_inc;
            if (steps_inc >= on_wait) begin
              next_state = rsq_pkg::RSQ_ON;
            end
          end
        end
        rsq_pkg::RSQ_WAIT_OFF: begin
          if (tick_off) begin
            next_steps = steps_inc;
            if (steps_inc >= off_wait) begin
              next_state = rsq_pkg::RSQ_OFF;
            end
          end
        end
        rsq_pkg::RSQ_OFF, rsq_pkg::RSQ_ON: begin
          next_steps = steps;
        end
        default: begin
          next_state = rsq_pkg::RSQ_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= rsq_pkg::RSQ_OFF;
      steps <= rsq_pkg::WAIT_ZERO;
      run <= 1'b0;
    end else begin
      state <= next_state;
      steps <= next_steps;
      run <= next_run;
    end
  end

endmodule

// *** src/rsq_top.sv ***
/*
  rail sequencing registers: level codes, second linear rail control and
  delay-sequenced enables for two converters, two linear rails and the
  auxiliary output.
  assumes a serial-interface engine elsewhere turns host transfers into
  byte writes and reads on the register port, all on clk_sys.
*/
// Contract
// - second linear rail off unless on-bit set
// - pin gate ands enable pin into rail
// - bleed resistor on when rail off, resets set
// - five-bit level code, reserved bits reset zero
// - converter start delay from pin rise, low nibble
// - linear rail start delay from pin rise
// - converter stop delay from pin fall, high nibble
// - linear rail stop delay from pin fall
// - aux output falls delayed after pin fall
// - start step 0.5 ms, 1 ms if selected
// - stop step 0.5 ms, 1 ms if selected
// - scale selects in config bits 6, 5
// - aux output rises delayed after pin rise
`timescale 1ns/10ps
module rsq_top #(
  parameter int STEP_CYCLES = rsq_pkg::STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic en_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic conv0_run,
  output logic conv1_run,
  output logic linreg0_run,
  output logic linreg1_run,
  output logic linreg1_bleed,
  output logic aux_out,
  output logic [rsq_pkg::LEVEL_MSB:0] linreg0_level_code,
  output logic [rsq_pkg::LEVEL_MSB:0] linreg1_level_code
);

  localparam int NCH = 5;
  localparam logic [rsq_pkg::STEP_CNT_W-1:0] STEP_LAST = rsq_pkg::STEP_CNT_W'(STEP_CYCLES - 1);
  localparam logic [rsq_pkg::STEP_CNT_W-1:0] STEP_ZERO = '0;
  localparam logic [rsq_pkg::STEP_CNT_W-1:0] STEP_ONE = rsq_pkg::STEP_CNT_W'(1);

  // ==========================================================
  // registers
  logic [7:0] linreg1_control;
  logic [7:0] linreg0_level;
  logic [7:0] linreg1_level;
  logic [7:0] conv0_sequence_delays;
  logic [7:0] conv1_sequence_delays;
  logic [7:0] linreg0_sequence_delays;
  logic [7:0] linreg1_sequence_delays;
  logic [7:0] aux_out_sequence_delays;
  logic [7:0] config_reg;

  wire wr_ctrl = reg_wr && (reg_addr == rsq_pkg::LINREG1_CONTROL_OFS);
  wire wr_lvl0 = reg_wr && (reg_addr == rsq_pkg::LINREG0_LEVEL_OFS);
  wire wr_lvl1 = reg_wr && (reg_addr == rsq_pkg::LINREG1_LEVEL_OFS);
  wire wr_c0 = reg_wr && (reg_addr == rsq_pkg::CONV0_SEQ_OFS);
  wire wr_c1 = reg_wr && (reg_addr == rsq_pkg::CONV1_SEQ_OFS);
  wire wr_l0 = reg_wr && (reg_addr == rsq_pkg::LINREG0_SEQ_OFS);
  wire wr_l1 = reg_wr && (reg_addr == rsq_pkg::LINREG1_SEQ_OFS);
  wire wr_aux = reg_wr && (reg_addr == rsq_pkg::AUX_OUT_SEQ_OFS);
  wire wr_cfg = reg_wr && (reg_addr == rsq_pkg::CONFIG_OFS);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linreg1_control <= rsq_pkg::LINREG1_CONTROL_RST;
    end else if (wr_ctrl) begin
      linreg1_control <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linreg0_level <= rsq_pkg::LEVEL_RST;
    end else if (wr_lvl0) begin
      linreg0_level <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linreg1_level <= rsq_pkg::LEVEL_RST;
    end else if (wr_lvl1) begin
      linreg1_level <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv0_sequence_delays <= rsq_pkg::SEQ_RST;
    end else if (wr_c0) begin
      conv0_sequence_delays <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv1_sequence_delays <= rsq_pkg::SEQ_RST;
    end else if (wr_c1) begin
      conv1_sequence_delays <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linreg0_sequence_delays <= rsq_pkg::SEQ_RST;
    end else if (wr_l0) begin
      linreg0_sequence_delays <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      linreg1_sequence_delays <= rsq_pkg::SEQ_RST;
    end else if (wr_l1) begin
      linreg1_sequence_delays <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aux_out_sequence_delays <= rsq_pkg::SEQ_RST;
    end else if (wr_aux) begin
      aux_out_sequence_delays <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      config_reg <= rsq_pkg::CONFIG_RST;
    end else if (wr_cfg) begin
      config_reg <= reg_wdata;
    end
  end

  // ==========================================================
  // read mux, unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    unique case (reg_addr)
      rsq_pkg::LINREG1_CONTROL_OFS: next_rdata = linreg1_control;
      rsq_pkg::LINREG0_LEVEL_OFS: next_rdata = linreg0_level;
      rsq_pkg::LINREG1_LEVEL_OFS: next_rdata = linreg1_level;
      rsq_pkg::CONV0_SEQ_OFS: next_rdata = conv0_sequence_delays;
      rsq_pkg::CONV1_SEQ_OFS: next_rdata = conv1_sequence_delays;
      rsq_pkg::LINREG0_SEQ_OFS: next_rdata = linreg0_sequence_delays;
      rsq_pkg::LINREG1_SEQ_OFS: next_rdata = linreg1_sequence_delays;
      rsq_pkg::AUX_OUT_SEQ_OFS: next_rdata = aux_out_sequence_delays;
      rsq_pkg::CONFIG_OFS: next_rdata = config_reg;
      default: next_rdata = rsq_pkg::READ_NONE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= rsq_pkg::READ_NONE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // field decode
  wire linreg1_on_bit = linreg1_control[rsq_pkg::ON_BIT_POS];
  wire linreg1_pin_gate = linreg1_control[rsq_pkg::PIN_GATE_POS];
  wire linreg1_bleed_bit = linreg1_control[rsq_pkg::BLEED_BIT_POS];
  wire start_scale = config_reg[rsq_pkg::START_SCALE_POS];
  wire stop_scale = config_reg[rsq_pkg::STOP_SCALE_POS];

  // reserved upper bits are stored but never reach the regulators
  // codes 0x1A-0x1F are passed through as written; the host must avoid them
  assign linreg0_level_code = linreg0_level[rsq_pkg::LEVEL_MSB:0];
  assign linreg1_level_code = linreg1_level[rsq_pkg::LEVEL_MSB:0];

  // ==========================================================
  // enable pin synchroniser and edges
  logic en_meta;
  logic en_sync;
  logic en_prev;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      en_prev <= 1'b0;
    end else begin
      en_meta <= en_pin;
      en_sync <= en_meta;
      en_prev <= en_sync;
    end
  end
  wire en_rise = en_sync && !en_prev;
  wire en_fall = !en_sync && en_prev;

  // ==========================================================
  // step timebase, restarted on each pin edge so the first step is whole
  logic [rsq_pkg::STEP_CNT_W-1:0] step_cnt;
  logic half_phase;
  wire half_tick = (step_cnt == STEP_LAST);
  wire ms_tick = half_tick && half_phase;
  wire tick_on = start_scale ? ms_tick : half_tick;
  wire tick_off = stop_scale ? ms_tick : half_tick;

  always_ff @(posedge clk_sys) begin
    if (reset || en_rise || en_fall) begin
      step_cnt <= STEP_ZERO;
      half_phase <= 1'b0;
    end else if (half_tick) begin
      step_cnt <= STEP_ZERO;
      half_phase <= !half_phase;
    end else begin
      step_cnt <= step_cnt + STEP_ONE;
    end
  end

  // ==========================================================
  // sequencing channels: conv0, conv1, linreg0, linreg1, aux_out
  logic [NCH-1:0] seq_run;

  rsq_channel u_ch_conv0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .en_rise(en_rise),
    .en_fall(en_fall),
    .tick_on(tick_on),
    .tick_off(tick_off),
    .on_wait(conv0_sequence_delays[rsq_pkg::ON_WAIT_MSB:0]),
    .off_wait(conv0_sequence_delays[rsq_pkg::OFF_WAIT_MSB:rsq_pkg::OFF_WAIT_LSB]),
    .run(seq_run[0])
  );

  rsq_channel u_ch_conv1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .en_rise(en_rise),
    .en_fall(en_fall),
    .tick_on(tick_on),
    .tick_off(tick_off),
    .on_wait(conv1_sequence_delays[rsq_pkg::ON_WAIT_MSB:0]),
    .off_wait(conv1_sequence_delays[rsq_pkg::OFF_WAIT_MSB:rsq_pkg::OFF_WAIT_LSB]),
    .run(seq_run[1])
  );

  rsq_channel u_ch_linreg0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .en_rise(en_rise),
    .en_fall(en_fall),
    .tick_on(tick_on),
    .tick_off(tick_off),
    .on_wait(linreg0_sequence_delays[rsq_pkg::ON_WAIT_MSB:0]),
    .off_wait(linreg0_sequence_delays[rsq_pkg::OFF_WAIT_MSB:rsq_pkg::OFF_WAIT_LSB]),
    .run(seq_run[2])
  );

  rsq_channel u_ch_linreg1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .en_rise(en_rise),
    .en_fall(en_fall),
    .tick_on(tick_on),
    .tick_off(tick_off),
    .on_wait(linreg1_sequence_delays[rsq_pkg::ON_WAIT_MSB:0]),
    .off_wait(linreg1_sequence_delays[rsq_pkg::OFF_WAIT_MSB:rsq_pkg::OFF_WAIT_LSB]),
    .run(seq_run[3])
  );

  rsq_channel u_ch_aux_out (
    .clk_sys(clk_sys),
    .reset(reset),
    .en_rise(en_rise),
    .en_fall(en_fall),
    .tick_on(tick_on),
    .tick_off(tick_off),
    .on_wait(aux_out_sequence_delays[rsq_pkg::ON_WAIT_MSB:0]),
    .off_wait(aux_out_sequence_delays[rsq_pkg::OFF_WAIT_MSB:rsq_pkg::OFF_WAIT_LSB]),
    .run(seq_run[4])
  );

  // ==========================================================
  // rail outputs
  // with the pin gate and on-bit set the rail follows the sequenced pin state
  wire linreg1_allow = linreg1_pin_gate ? seq_run[3] : 1'b1;
  wire next_linreg1_run = linreg1_on_bit && linreg1_allow;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv0_run <= 1'b0;
      conv1_run <= 1'b0;
      linreg0_run <= 1'b0;
      linreg1_run <= 1'b0;
      linreg1_bleed <= 1'b0;
      aux_out <= 1'b0;
    end else begin
      conv0_run <= seq_run[0];
      conv1_run <= seq_run[1];
      linreg0_run <= seq_run[2];
      linreg1_run <= next_linreg1_run;
      linreg1_bleed <= !next_linreg1_run && linreg1_bleed_bit;
      aux_out <= seq_run[4];
    end
  end

endmodule

// *** verif/rsq_asserts.sv ***
/*
  port-level assertions for rsq_top.
  assumes binding from the bench top, one clock, synchronous reset.
*/
`timescale 1ns/10ps
module rsq_asserts #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic en_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic conv0_run,
  input wire logic conv1_run,
  input wire logic linreg0_run,
  input wire logic linreg1_run,
  input wire logic linreg1_bleed,
  input wire logic aux_out,
  input wire logic [rsq_pkg::LEVEL_MSB:0] linreg0_level_code,
  input wire logic [rsq_pkg::LEVEL_MSB:0] linreg1_level_code
);
  // ==========
  // shadows of host writes and pin-level counters
  // margin covers sync flops and edge detect past the longest delay
  localparam int LIM = 30 * STEP_CYCLES + 12;
  logic [7:0] ctl, lv0, lv1;
  logic [3:0] runs;
  int hi_cnt, lo_cnt;
  assign runs = {aux_out, linreg0_run, conv1_run, conv0_run};
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl <= 8'h04;
      lv0 <= 8'h00;
      lv1 <= 8'h00;
      hi_cnt <= 0;
      lo_cnt <= 0;
    end else begin
      if (reg_wr && reg_addr == 8'h09) ctl <= reg_wdata;
      if (reg_wr && reg_addr == 8'h0A) lv0 <= reg_wdata;
      if (reg_wr && reg_addr == 8'h0B) lv1 <= reg_wdata;
      hi_cnt <= en_pin ? (hi_cnt < LIM ? hi_cnt + 1 : LIM) : 0;
      lo_cnt <= !en_pin ? (lo_cnt < LIM ? lo_cnt + 1 : LIM) : 0;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence up_seen;
    (runs & ~$past(runs)) != 4'h0;
  endsequence
  sequence down_seen;
    (~runs & $past(runs)) != 4'h0;
  endsequence
  sequence rail_idle;
    !$past(reset) && $past(ctl[2]) && !linreg1_run && !$past(linreg1_run);
  endsequence
  a_rail_needs_bit: assert property (!$past(ctl[0]) |-> !linreg1_run)
    else $error("second linear rail on with on-bit clear");
  a_bit_only_ctl: assert property ($past(ctl[0]) && !$past(ctl[1]) |-> linreg1_run)
    else $error("second linear rail off with on-bit set and no pin gate");
  a_bleed_excl: assert property (linreg1_run && $past(linreg1_run) |-> !linreg1_bleed)
    else $error("bleed resistor on while rail runs");
  a_bleed_on: assert property (rail_idle |-> linreg1_bleed)
    else $error("bleed resistor off while rail off with bleed bit set");
  a_level_copy: assert property ({linreg0_level_code, linreg1_level_code} == {lv0[4:0], lv1[4:0]})
    else $error("level code differs from written value");
  a_rise_cause: assert property (up_seen |-> $past(en_pin, 4))
    else $error("output rose without enable pin high");
  a_fall_cause: assert property (down_seen |-> !$past(en_pin, 4))
    else $error("output fell without enable pin low");
  a_all_on: assert property (hi_cnt == LIM |-> runs == 4'hF)
    else $error("output still off after longest start delay");
  a_all_off: assert property (lo_cnt == LIM |-> runs == 4'h0)
    else $error("output still on after longest stop delay");
endmodule

// *** verif/rsq_host.sv ***
/*
  host model: byte writes and reads on the register port, enable pin level.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/10ps
module rsq_host (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic en_pin,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  initial begin
    en_pin = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // callers keep level codes at 0x19 or below
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic pin(input logic v);
    @(negedge clk_sys);
    en_pin = v;
  endtask
endmodule

// *** verif/tb_top.sv ***
/*
  self-checking bench for rsq_top.
  assumes the host model drives all register-port and pin inputs.
*/
`timescale 1ns/10ps
module tb_top;
  localparam int STEP = 4;
  logic clk_sys, reset;
  wire logic en_pin, reg_wr, conv0_run, conv1_run, linreg0_run, linreg1_run, linreg1_bleed, aux_out;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic [4:0] lvc0, lvc1, runs;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  assign runs = {aux_out, linreg1_run, linreg0_run, conv1_run, conv0_run};
  rsq_top #(.STEP_CYCLES(STEP)) rsq_top_inst (.clk_sys(clk_sys), .reset(reset), .en_pin(en_pin),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv0_run(conv0_run), .conv1_run(conv1_run), .linreg0_run(linreg0_run), .linreg1_run(linreg1_run),
    .linreg1_bleed(linreg1_bleed), .aux_out(aux_out), .linreg0_level_code(lvc0), .linreg1_level_code(lvc1));
  rsq_host rsq_host_inst (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .en_pin(en_pin),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  // ==========
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] ofs [10] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h13, 8'h12};
    for (int i = 0; i < 10; i++) begin
      rsq_host_inst.rd(ofs[i], d);
      chk(d, i == 0 ? 8'h04 : 8'h00);
      rsq_host_inst.wr(ofs[i], 8'hA5);
      rsq_host_inst.rd(ofs[i], d);
      chk(d, i == 9 ? 8'h00 : 8'hA5);
    end
    chk(lvc0, 5'h05);
    rsq_host_inst.wr(8'h0B, 8'h19);
    rsq_host_inst.rd(8'h0B, d);
    chk(lvc1, 5'h19);
    $display("register test done");
  endtask
  task automatic t_rail(input logic [7:0] v, input logic run, input logic bl);
    rsq_host_inst.wr(8'h09, v);
    repeat (3) @(negedge clk_sys);
    chk({linreg1_run, linreg1_bleed}, {run, bl});
    $display("rail control %h test done", v);
  endtask
  // pin gate set so the second linear rail follows its own delays
  task automatic t_seq(input logic [7:0] cfg);
    logic [7:0] dly [5] = '{8'hF0, 8'h01, 8'h12, 8'h37, 8'h2F};
    int t [5];
    int e;
    rsq_host_inst.wr(8'h13, cfg);
    rsq_host_inst.wr(8'h09, 8'h03);
    for (int i = 0; i < 5; i++) rsq_host_inst.wr(8'(8'h0C + i), dly[i]);
    for (int p = 1; p >= 0; p--) begin
      rsq_host_inst.pin(p[0]);
      t = '{-1, -1, -1, -1, -1};
      for (int c = 0; c < 140; c++) begin
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 5; i++) if (t[i] < 0 && runs[i] === p[0]) t[i] = c;
      end
      for (int i = 0; i < 5; i++) begin
        e = 4 + STEP * (cfg[p ? 6 : 5] ? 2 : 1) * (p ? dly[i][3:0] : dly[i][7:4]);
        chk(t[i] >= e - 1 && t[i] <= e + 1, 1'b1);
      end
    end
    $display("sequence config %h test done", cfg);
  endtask
  // pin drops long before the aux start delay ends
  task automatic t_abort;
    logic seen = 1'b0;
    rsq_host_inst.pin(1'b1);
    repeat (20) @(negedge clk_sys);
    rsq_host_inst.pin(1'b0);
    repeat (80) begin
      @(negedge clk_sys);
      seen |= aux_out;
    end
    chk(seen, 1'b0);
    $display("abort test done");
  endtask
  // ==========
  // clock, reset, run
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    t_regs();
    t_rail(8'h00, 1'b0, 1'b0);
    t_rail(8'h04, 1'b0, 1'b1);
    t_rail(8'h01, 1'b1, 1'b0);
    t_rail(8'h05, 1'b1, 1'b0);
    t_rail(8'h07, 1'b0, 1'b1);
    t_seq(8'h00);
    t_seq(8'h40);
    t_seq(8'h20);
    t_abort();
    give_verdict();
  end
endmodule
bind rsq_top rsq_asserts #(.STEP_CYCLES(STEP_CYCLES)) rsq_asserts_inst (.clk_sys(clk_sys), .reset(reset),
  .en_pin(en_pin), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .conv0_run(conv0_run), .conv1_run(conv1_run), .linreg0_run(linreg0_run), .linreg1_run(linreg1_run),
  .linreg1_bleed(linreg1_bleed), .aux_out(aux_out), .linreg0_level_code(linreg0_level_code),
  .linreg1_level_code(linreg1_level_code));
